// ===== include/sso_pkg.sv
// constants and types shared by the start and output control logic
// assumes a single 50 mhz clock and a 1 ms tick derived from it
`default_nettype none
package sso_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int SYNC_WINDOW_MS  = 500;
  localparam int ACT_DELAY_MS    = 50;   // inside the 100 ms bound
  localparam int START_PULSE_MS  = 80;
  localparam int POWERON_WAIT_MS = 2500;
  localparam int MS_W            = 12;
  // ----------------------------------------------------------------
  // selector and states
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_RESET = 3'h0;  // position 1
  typedef enum logic [2:0] {
    SSO_OFF, SSO_ARMED, SSO_DELAY, SSO_ON, SSO_LOCK
  } sso_state_type;
endpackage
`default_nettype wire

// ===== logic/sso_tick.sv
// millisecond enable divider
// assumes clk at the package clock rate
`default_nettype none
module sso_tick
  import sso_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } sso_tick_type;
  sso_tick_type s_q, s_d;
  // count down, pulse one cycle on wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'h0) begin
      s_d.cnt = 32'(CYCLES - 1);
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end
  assign tick = s_q.tick;
endmodule
`default_nettype wire

// ===== logic/sso_ctrl.sv
// start function and output enable control for a two channel sensor
// assumes pins asynchronous to clk; reset_n is power-on reset
// Notes on behaviour
// - interlock monitored, no test pulses applied
// - third input unused or cancels delay; here it is only forwarded as delay_cancel_req
// - start function governs every output activation
// - automatic start energizes within 100 ms
// - outputs drop within 20 ms always
// - manual start needs start and inputs
// - monitored start energizes on falling edge
// - monitored start energizes within 100 ms
// - startup test needs inputs cycled off, on
// - inputs inactive at power-up pass test
// - selector decodes mode, test, dynamization
// - safe state is outputs off
`default_nettype none
module sso_ctrl
  import sso_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       chan_a_input,
  input  wire logic       chan_b_input,
  input  wire logic       start_input,
  input  wire logic       delay_cancel_input,
  input  wire logic [2:0] start_selector,
  output logic            outputs_energized,
  output logic            sync_fault,
  output logic            dynamization_en,
  output logic            delay_cancel_req,
  output logic            test_pulse_en
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]    a_sync, b_sync, s_sync, c_sync;
    logic          sel_done;
    logic          mon_mode, test_mode, dyn_mode;
    logic          test_seen_off;
    logic          start_prev;
    logic          start_long;
    logic          inputs_seen;
    logic [MS_W-1:0] sync_ms, start_ms, pwr_ms, dly_ms;
    sso_state_type st;
    logic          out, fault, cancel;
  } sso_ctrl_type;
  sso_ctrl_type s_q, s_d;
  logic tick;
  // divider is a parameter so a bench can shorten the millisecond
  sso_tick #(
    .CYCLES (TICK_DIV)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick)
  );
  // saturating millisecond counter, shared by all timers
  function automatic logic [MS_W-1:0] ms_inc(logic [MS_W-1:0] v,
                                             logic t);
    return (t && v != '1) ? v + 1'b1 : v;
  endfunction
  logic a, b, s, both, any, one;
  assign a    = s_q.a_sync[1];
  assign b    = s_q.b_sync[1];
  assign s    = s_q.s_sync[1];
  assign both = a & b;
  assign any  = a | b;
  assign one  = a ^ b;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // two flop synchronisers; only stage one feeds stage two
    s_d.a_sync = {s_q.a_sync[0], chan_a_input};
    s_d.b_sync = {s_q.b_sync[0], chan_b_input};
    s_d.s_sync = {s_q.s_sync[0], start_input};
    s_d.c_sync = {s_q.c_sync[0], delay_cancel_input};
    s_d.cancel = s_q.c_sync[1];
    s_d.pwr_ms = ms_inc(s_q.pwr_ms, tick);
    // selector caught once, unsynchronised, at the second millisecond tick, then frozen
    if (!s_q.sel_done && s_q.pwr_ms == 12'h2) begin
      s_d.sel_done  = 1'b1;
      s_d.mon_mode  = start_selector[1];
      s_d.test_mode = start_selector[0];       // even positions
      s_d.dyn_mode  = ~start_selector[2];      // positions 1 to 4
      // without startup test the gate is open from the start
      s_d.test_seen_off = ~any | ~start_selector[0];
    end
    if (s_q.sel_done && !any) s_d.test_seen_off = 1'b1;
    // start pulse length and edge for monitored start
    s_d.start_prev = s;
    s_d.start_ms = s ? ms_inc(s_q.start_ms, tick) : '0;
    if (s && s_q.start_ms >= MS_W'(START_PULSE_MS))
      s_d.start_long = 1'b1;
    if (s && both) s_d.inputs_seen = 1'b1;
    // discrepancy timer between channels
    s_d.sync_ms = one ? ms_inc(s_q.sync_ms, tick) : '0;
    s_d.dly_ms = ms_inc(s_q.dly_ms, tick);
    unique case (s_q.st)
      SSO_OFF: begin
        s_d.out = 1'b0;
        if (s_q.sel_done && s_q.test_seen_off && both)
          s_d.st = SSO_ARMED;
        if (!both) begin
          s_d.start_long  = 1'b0;
          s_d.inputs_seen = 1'b0;
        end
      end
      SSO_ARMED: begin
        if (!both) s_d.st = SSO_OFF;
        else if (s_q.mon_mode) begin
          // falling edge after a long enough pulse
          if (s_q.start_prev && !s && s_q.start_long &&
              s_q.pwr_ms >= MS_W'(POWERON_WAIT_MS)) begin
            s_d.st = SSO_DELAY;
            s_d.dly_ms = '0;
          end else if (!s) s_d.start_long = 1'b0;
        end else if (s) begin
          s_d.st = SSO_DELAY;
          s_d.dly_ms = '0;
        end
      end
      SSO_DELAY: begin
        if (!both || (!s_q.mon_mode && !s)) s_d.st = SSO_OFF;
        else if (s_q.dly_ms >= MS_W'(ACT_DELAY_MS)) begin
          s_d.st = SSO_ON;
          s_d.out = 1'b1;
        end
      end
      SSO_ON: begin
        // one cycle drop, well inside the response bound
        if (!both) begin
          s_d.st = SSO_OFF;
          s_d.out = 1'b0;
          s_d.start_long = 1'b0;
          s_d.inputs_seen = 1'b0;
        end
      end
      SSO_LOCK: begin
        s_d.out = 1'b0;
        if (!any) begin
          s_d.st = SSO_OFF;
          s_d.fault = 1'b0;
        end
      end
    endcase
    // interlock: one channel long without the other locks out
    if (s_q.sync_ms >= MS_W'(SYNC_WINDOW_MS) &&
        s_q.st != SSO_ON) begin
      s_d.st = SSO_LOCK;
      s_d.out = 1'b0;
      s_d.fault = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.st <= SSO_OFF;
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------------------------------
  // outputs, all from flops except test_pulse_en, tied low
  // ----------------------------------------------------------------
  assign outputs_energized = s_q.out;
  assign sync_fault        = s_q.fault;
  assign dynamization_en   = s_q.dyn_mode;
  assign delay_cancel_req  = s_q.cancel;
  assign test_pulse_en     = 1'b0 & s_q.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  drop_fast_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_q.st == SSO_ON && !both) |=> !outputs_energized)
    else $error("outputs not dropped after input loss");
  safe_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    outputs_energized |-> $past(both))
    else $error("outputs on without both inputs");
  lock_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_q.st == SSO_LOCK) |-> !outputs_energized)
    else $error("outputs on during lockout");
  on_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(outputs_energized) |-> $past(s_q.st) == SSO_DELAY)
    else $error("outputs rose without activation delay");
  no_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    !test_pulse_en)
    else $error("test pulses applied");
  sel_frozen_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(s_q.sel_done) |-> $stable(dynamization_en))
    else $error("selector changed after sampling");
  test_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_q.st == SSO_ARMED) |-> s_q.test_seen_off)
    else $error("armed before startup test passed");
  man_start_a: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(s_q.st == SSO_DELAY) && !s_q.mon_mode) |-> $past(s))
    else $error("manual start without start input");
endmodule
`default_nettype wire

// ===== tb/sso_sensor_model.sv
// two-channel sensor and start source in front of the control block
// assumes clk at 50 mhz; the bench moves guard and button at negedge
`default_nettype none
module sso_sensor_model #(
  parameter int RECOVERY_CYCLES = 200 * 50_000
) (
  input  wire logic clk,
  input  wire logic guard_closed,
  input  wire logic start_press,
  output logic      chan_a_input,
  output logic      chan_b_input,
  output logic      start_input
);
  int unsigned off_cnt = RECOVERY_CYCLES;
  logic        a_q = 1'b0;
  logic        b_q = 1'b0;
  logic        st_q = 1'b0;
  assign chan_a_input = a_q;
  assign chan_b_input = b_q;
  assign start_input  = st_q;
  // ----------------------------------------------------------------
  // channel drive
  // ----------------------------------------------------------------
  // both channels switch together, so the window is always met
  // an opened guard is held low for the full recovery time
  always @(negedge clk) begin
    st_q <= start_press;
    if (!guard_closed) begin
      off_cnt <= 0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (off_cnt < RECOVERY_CYCLES) begin
      off_cnt <= off_cnt + 1;
    end else begin
      a_q <= 1'b1;
      b_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/safety_start_output_control_bench.sv
// self-checking bench for the start and output control block
// assumes the package, design files and sensor model compile first
`default_nettype none
module safety_start_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sso_pkg::*;
  // a short millisecond keeps the run small; all ms counts still hold
  localparam int MS = 20;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       guard_closed = 1'b1;
  logic       start_press = 1'b1;
  logic       delay_cancel_input = 1'b0;
  logic [2:0] start_selector = SEL_RESET;
  logic       chan_a, chan_b, start_in, out_on, fault;
  logic       dyn_en, cancel_req, pulse_en;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cycles = 0;
  // ----------------------------------------------------------------
  // parts
  // ----------------------------------------------------------------
  sso_sensor_model #(.RECOVERY_CYCLES(200 * MS)) model (.clk(clk),
    .guard_closed(guard_closed),
    .start_press(start_press), .chan_a_input(chan_a),
    .chan_b_input(chan_b), .start_input(start_in));
  sso_ctrl #(.TICK_DIV(MS)) dut (.clk(clk), .reset_n(reset_n),
    .chan_a_input(chan_a),
    .chan_b_input(chan_b), .start_input(start_in),
    .delay_cancel_input(delay_cancel_input),
    .start_selector(start_selector), .outputs_energized(out_on),
    .sync_fault(fault), .dynamization_en(dyn_en),
    .delay_cancel_req(cancel_req), .test_pulse_en(pulse_en));
  // clock and a hang guard sized above all three scenarios together
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90_000) begin
      error_cnt++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // power-on: two cycles low, then wait past selector sampling
  task automatic do_reset(input logic [2:0] sel);
    @(negedge clk);
    reset_n = 1'b0;
    start_selector = sel;
    repeat (2) @(negedge clk);
    check(out_on, 1'b0);
    check(pulse_en, 1'b0);
    reset_n = 1'b1;
    repeat (3 * MS) @(negedge clk);
  endtask
  // bounded wait for the output level, then compare
  task automatic wait_out(input logic tgt, input int limit,
                          input logic exp);
    int n;
    n = 0;
    while (out_on !== tgt && n < limit) begin
      @(negedge clk);
      n++;
    end
    check(out_on, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // channels already on at power-up must be cycled before energizing
  task automatic t_startup_test();
    do_reset(3'h1);
    check(dyn_en, 1'b1);
    wait_out(1'b1, 60 * MS, 1'b0);
    guard_closed = 1'b0;
    repeat (MS) @(negedge clk);
    guard_closed = 1'b1;
    wait_out(1'b1, 300 * MS, 1'b1);
    delay_cancel_input = 1'b1;
    repeat (4) @(negedge clk);
    check(cancel_req, 1'b1);
  endtask
  // button start without startup test; selector frozen after sampling
  task automatic t_manual_start();
    start_press = 1'b0;
    delay_cancel_input = 1'b0;
    do_reset(3'h4);
    check(dyn_en, 1'b0);
    start_selector = 3'h0;
    repeat (MS) @(negedge clk);
    check(dyn_en, 1'b0);
    wait_out(1'b1, 60 * MS, 1'b0);
    start_press = 1'b1;
    wait_out(1'b1, 100 * MS, 1'b1);
    guard_closed = 1'b0;
    wait_out(1'b0, 20 * MS, 1'b0);
  endtask
  // monitored start from a controller, dynamization enabled there
  // early and short pulses are refused, a long one after the power-on
  // wait energizes on its falling edge
  task automatic t_monitored_start();
    guard_closed = 1'b1;
    start_press = 1'b0;
    do_reset(3'h2);
    check(dyn_en, 1'b1);
    repeat (300 * MS) @(negedge clk);
    start_press = 1'b1;
    repeat (100 * MS) @(negedge clk);
    start_press = 1'b0;
    wait_out(1'b1, 100 * MS, 1'b0);
    repeat (2100 * MS) @(negedge clk);
    start_press = 1'b1;
    repeat (40 * MS) @(negedge clk);
    start_press = 1'b0;
    wait_out(1'b1, 100 * MS, 1'b0);
    start_press = 1'b1;
    repeat (100 * MS) @(negedge clk);
    check(out_on, 1'b0);
    start_press = 1'b0;
    wait_out(1'b1, 100 * MS, 1'b1);
  endtask
  initial begin
    t_startup_test();
    t_manual_start();
    t_monitored_start();
    final_report();
  end
endmodule
`default_nettype wire
